/* verilog/ovcfg_pkg.sv */
// constants for the output overvoltage limit and response command set
// assumes a 250 MHz core clock and command codes decoded upstream
package ovcfg_pkg;
	// command codes of the three registers
	localparam logic [7:0]  CMD_OV_FAULT_THR  = 8'h40;
	localparam logic [7:0]  CMD_OV_FAULT_ACT  = 8'h41;
	localparam logic [7:0]  CMD_OV_WARN_THR   = 8'h42;
	// register widths and reset values
	localparam int          MANT_W            = 12;
	localparam logic [15:0] FAULT_THR_RESET   = 16'h0290;
	localparam logic [7:0]  FAULT_ACT_RESET   = 8'hBF;
	localparam logic [15:0] WARN_THR_RESET    = 16'h0267;
	// linear format exponent, fixed; one count is 1.95 mV
	localparam int          VOUT_EXPONENT     = -9;
	// fault action field layout
	localparam int          ACT_SELECT_BIT    = 7;
	localparam int          ACT_ZERO_BIT      = 6;
	localparam int          ACT_RETRY_HI      = 5;
	localparam int          ACT_RETRY_LO      = 3;
	localparam logic [2:0]  ACT_DELAY_CODE    = 3'h7;
	localparam logic [2:0]  RETRY_NEVER       = 3'h0;
	localparam logic [2:0]  RETRY_ALWAYS      = 3'h7;
	localparam int          RETRY_RAMPS       = 7;
	// nonvolatile backing: low mantissa bits are not kept
	localparam int          NV_FAULT_LO       = 4;
	localparam int          WARN_DIV_SHIFT    = 4;
	// range limits against the feedback divider product
	localparam int          SCALE_W           = 16;
	localparam int          SCALE_FRAC        = 12;
	localparam int          PROD_W            = MANT_W + SCALE_W;
	localparam logic [PROD_W-1:0] FAULT_PROD_MAX = PROD_W'(922) << SCALE_FRAC;
	localparam logic [PROD_W-1:0] WARN_PROD_MIN  = PROD_W'(269) << SCALE_FRAC;
	// status bit positions
	localparam int          SB_OV_FAULT       = 5;
	localparam int          SB_CML            = 1;
	localparam int          SB_OTHER          = 0;
	localparam int          SW_VOUT           = 15;
	localparam int          SV_OV_FAULT       = 7;
	localparam int          SV_OV_WARN        = 6;
	localparam int          SC_INVALID_DATA   = 6;
	// timing
	localparam int          CLOCK_PERIOD_NS   = 4;
	localparam int          RAMP_TIME_NS      = 1000000;
	localparam int          CNT_W             = 32;
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_RETRY_WAIT, ST_LATCHED} ovcfg_state_type;
endpackage

/* verilog/ovcfg_top.sv */
// output overvoltage threshold, warning and fault response logic
// assumes command strobes, measurement and setpoint come from logic on CLOCK_I
//
// Contract
// (R01) bad fault threshold write is dropped, flags communication and invalid data, alerts
// (R02) fault threshold accepted only above warning and below 922 over divider
// (R03) thresholds are 12-bit unsigned mantissa, upper four bits read zero
// (R04) fault threshold resets to 656 counts
// (R05) store keeps fault threshold without its low four bits
// (R06) overvoltage fault sets byte, word and vout flags and alerts
// (R07) action register: select bit 7, zero bit 6, retry 5:3, 111 low
// (R08) default response is shutdown then restart after seven ramp times
// (R09) select 0 keeps running but still flags and alerts
// (R10) select 1 shuts down and follows retry policy
// (R11) retry 000 stays off until faults are cleared
// (R12) retry 111 restarts endlessly until commanded off
// (R13) retry writes other than 000 or 111 are rejected and flagged
// (R14) only retry bit 5 is kept, restored to all three bits
// (R15) bad warning threshold write is dropped, flagged, alerts
// (R16) warning accepted above setpoint, below fault, divider product above 269
// (R17) overvoltage warning sets other, word and vout flags and alerts
// (R18) warning threshold has 12-bit mantissa, default 615 counts
// (R19) restored warning is fault minus fault/16, else fault minus one
// (R20) fault or warning declared when measured counts exceed the threshold
`timescale 1ns/100ps
`default_nettype none
module ovcfg_top
	import ovcfg_pkg::*;
#(
	parameter int RAMP_CYCLES = RAMP_TIME_NS / CLOCK_PERIOD_NS
) (
	input  wire logic                    CLOCK_I,
	input  wire logic                    RST_I,
	input  wire logic                    CMD_WR_I,
	input  wire logic                    CMD_RD_I,
	input  wire logic [7:0]              CMD_CODE_I,
	input  wire logic [15:0]             CMD_DATA_I,
	input  wire logic                    STORE_I,
	input  wire logic                    RESTORE_I,
	input  wire logic                    CLEAR_FAULTS_I,
	input  wire logic                    ENABLE_I,
	input  wire logic                    ALERT_MASK_I,
	input  wire logic [ovcfg_pkg::MANT_W-1:0]  VOUT_MEAS_I,
	input  wire logic [ovcfg_pkg::MANT_W-1:0]  VOUT_SETPOINT_I,
	input  wire logic [ovcfg_pkg::SCALE_W-1:0] VOUT_SCALE_LOOP_I,
	output logic [15:0]                  RD_DATA_O,
	output logic                         RD_VALID_O,
	output logic [7:0]                   STATUS_BYTE_O,
	output logic [15:0]                  STATUS_WORD_O,
	output logic [7:0]                   STATUS_VOUT_O,
	output logic [7:0]                   STATUS_CML_O,
	output logic                         ALERT_O,
	output logic                         OUTPUT_EN_O
);
	import ovcfg_pkg::*;

	localparam logic [CNT_W-1:0] RETRY_CYCLES = CNT_W'(RETRY_RAMPS * RAMP_CYCLES);

	// mantissa times divider ratio, used by both range checks
	function automatic logic [PROD_W-1:0] scaled(input logic [MANT_W-1:0] m,
		input logic [SCALE_W-1:0] s);
		scaled = PROD_W'(m) * PROD_W'(s);
	endfunction

	// warning derived from a fault value
	function automatic logic [MANT_W-1:0] warn_from_fault(input logic [MANT_W-1:0] f,
		input logic [MANT_W-1:0] setp);
		logic [MANT_W-1:0] w;
		w = f - (f >> WARN_DIV_SHIFT);
		warn_from_fault = (w > setp) ? w : f - MANT_W'(1);
	endfunction

	logic [MANT_W-1:0]            fault_thr;
	logic [MANT_W-1:0]            warn_thr;
	logic [7:0]                   fault_act;
	logic [MANT_W-1:NV_FAULT_LO]  nv_fault;
	logic                         nv_select;
	logic                         nv_retry;
	logic [MANT_W-1:0]            next_fault_thr;
	logic [MANT_W-1:0]            next_warn_thr;
	logic [7:0]                   next_fault_act;
	logic [MANT_W-1:NV_FAULT_LO]  next_nv_fault;
	logic                         next_nv_select;
	logic                         next_nv_retry;
	logic [MANT_W-1:0]            wr_mant;
	logic [2:0]                   wr_retry;
	logic                         wr_fault;
	logic                         wr_act;
	logic                         wr_warn;
	logic                         fault_ok;
	logic                         act_ok;
	logic                         warn_ok;
	logic                         reject;
	logic                         ov_fault_det;
	logic                         ov_warn_det;
	logic [MANT_W-1:0]            rest_fault;

	assign wr_mant  = CMD_DATA_I[MANT_W-1:0]; // upper four bits are read-only [R03]
	assign wr_retry = CMD_DATA_I[ACT_RETRY_HI:ACT_RETRY_LO];
	assign wr_fault = CMD_WR_I && CMD_CODE_I == CMD_OV_FAULT_THR;
	assign wr_act   = CMD_WR_I && CMD_CODE_I == CMD_OV_FAULT_ACT;
	assign wr_warn  = CMD_WR_I && CMD_CODE_I == CMD_OV_WARN_THR;
	// range checks on incoming words
	assign fault_ok = wr_mant > warn_thr
		&& scaled(wr_mant, VOUT_SCALE_LOOP_I) < FAULT_PROD_MAX; // [R02]
	assign act_ok   = wr_retry == RETRY_NEVER || wr_retry == RETRY_ALWAYS; // [R13]
	assign warn_ok  = wr_mant > VOUT_SETPOINT_I && wr_mant < fault_thr
		&& scaled(wr_mant, VOUT_SCALE_LOOP_I) > WARN_PROD_MIN; // [R16]
	assign reject   = (wr_fault && !fault_ok) || (wr_act && !act_ok)
		|| (wr_warn && !warn_ok); // [R01] [R15]
	assign rest_fault = {nv_fault, NV_FAULT_LO'(0)};
	// comparator on measured counts, same units as the thresholds
	assign ov_fault_det = VOUT_MEAS_I > fault_thr; // [R20]
	assign ov_warn_det  = VOUT_MEAS_I > warn_thr; // [R20]

	// configuration and nonvolatile image; restore beats a write in the same cycle
	always_comb begin
		next_fault_thr = fault_thr;
		next_warn_thr  = warn_thr;
		next_fault_act = fault_act;
		next_nv_fault  = nv_fault;
		next_nv_select = nv_select;
		next_nv_retry  = nv_retry;
		if (RESTORE_I) begin
			next_fault_thr = rest_fault;
			next_warn_thr  = warn_from_fault(rest_fault, VOUT_SETPOINT_I); // [R19]
			next_fault_act = {nv_select, 1'b0, {3{nv_retry}}, ACT_DELAY_CODE}; // [R14]
		end else begin
			if (wr_fault && fault_ok)
				next_fault_thr = wr_mant; // [R02]
			if (wr_warn && warn_ok)
				next_warn_thr = wr_mant; // [R16]
			if (wr_act && act_ok)
				next_fault_act = {CMD_DATA_I[ACT_SELECT_BIT], 1'b0, wr_retry,
					ACT_DELAY_CODE}; // [R07]
		end
		if (STORE_I) begin
			next_nv_fault  = fault_thr[MANT_W-1:NV_FAULT_LO]; // [R05]
			next_nv_select = fault_act[ACT_SELECT_BIT];
			next_nv_retry  = fault_act[ACT_RETRY_HI]; // [R14]
		end
	end

	// configuration registers; defaults give shutdown with delayed restart
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			fault_thr <= FAULT_THR_RESET[MANT_W-1:0]; // [R04]
			warn_thr  <= WARN_THR_RESET[MANT_W-1:0]; // [R18]
			fault_act <= FAULT_ACT_RESET; // [R08]
			nv_fault  <= FAULT_THR_RESET[MANT_W-1:NV_FAULT_LO];
			nv_select <= FAULT_ACT_RESET[ACT_SELECT_BIT];
			nv_retry  <= FAULT_ACT_RESET[ACT_RETRY_HI];
		end else begin
			fault_thr <= next_fault_thr;
			warn_thr  <= next_warn_thr;
			fault_act <= next_fault_act;
			nv_fault  <= next_nv_fault;
			nv_select <= next_nv_select;
			nv_retry  <= next_nv_retry;
		end
	end

	logic [7:0]  status_byte;
	logic        status_vsum;
	logic [7:0]  status_vout;
	logic [7:0]  status_cml;
	logic [7:0]  next_status_byte;
	logic        next_status_vsum;
	logic [7:0]  next_status_vout;
	logic [7:0]  next_status_cml;

	// sticky flags; a set in the clearing cycle wins so no event is lost
	always_comb begin
		next_status_byte = CLEAR_FAULTS_I ? 8'h00 : status_byte;
		next_status_vsum = CLEAR_FAULTS_I ? 1'b0 : status_vsum;
		next_status_vout = CLEAR_FAULTS_I ? 8'h00 : status_vout;
		next_status_cml  = CLEAR_FAULTS_I ? 8'h00 : status_cml;
		if (reject) begin
			next_status_byte[SB_CML]         = 1'b1; // [R01] [R13] [R15]
			next_status_cml[SC_INVALID_DATA] = 1'b1;
		end
		if (ov_fault_det) begin
			next_status_byte[SB_OV_FAULT] = 1'b1; // [R06] [R09]
			next_status_vsum              = 1'b1;
			next_status_vout[SV_OV_FAULT] = 1'b1;
		end
		if (ov_warn_det) begin
			next_status_byte[SB_OTHER]   = 1'b1; // [R17]
			next_status_vsum             = 1'b1;
			next_status_vout[SV_OV_WARN] = 1'b1;
		end
	end

	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			status_byte <= 8'h00;
			status_vsum <= 1'b0;
			status_vout <= 8'h00;
			status_cml  <= 8'h00;
		end else begin
			status_byte <= next_status_byte;
			status_vsum <= next_status_vsum;
			status_vout <= next_status_vout;
			status_cml  <= next_status_cml;
		end
	end

	assign STATUS_BYTE_O = status_byte;
	assign STATUS_WORD_O = {status_vsum, 7'h00, status_byte};
	assign STATUS_VOUT_O = status_vout;
	assign STATUS_CML_O  = status_cml;
	// alert follows any pending flag; the mask only gates the line
	assign ALERT_O = !ALERT_MASK_I && (|status_byte || status_vsum); // [R06] [R09]

	ovcfg_state_type  state;
	ovcfg_state_type  next_state;
	logic [CNT_W-1:0] wait_cnt;
	logic [CNT_W-1:0] next_wait_cnt;

	// fault response; retry wait reloads on each shutdown
	always_comb begin
		next_state    = state;
		next_wait_cnt = wait_cnt;
		case (state)
			ST_IDLE: begin
				if (ENABLE_I)
					next_state = ST_RUN;
			end
			ST_RUN: begin
				if (!ENABLE_I)
					next_state = ST_IDLE;
				else if (ov_fault_det && fault_act[ACT_SELECT_BIT]) begin // [R10]
					if (fault_act[ACT_RETRY_HI:ACT_RETRY_LO] == RETRY_ALWAYS) begin
						next_state    = ST_RETRY_WAIT; // [R12]
						next_wait_cnt = RETRY_CYCLES; // [R08]
					end else
						next_state = ST_LATCHED; // [R11]
				end
			end
			ST_RETRY_WAIT: begin
				if (!ENABLE_I)
					next_state = ST_IDLE; // [R12]
				else if (wait_cnt <= CNT_W'(1))
					next_state = ST_RUN; // soft start again
				else
					next_wait_cnt = wait_cnt - CNT_W'(1);
			end
			ST_LATCHED: begin
				if (CLEAR_FAULTS_I)
					next_state = ST_IDLE; // [R11]
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			state    <= ST_IDLE;
			wait_cnt <= '0;
		end else begin
			state    <= next_state;
			wait_cnt <= next_wait_cnt;
		end
	end

	// enable comes straight from the state so shutdown lands in one cycle
	assign OUTPUT_EN_O = state == ST_RUN; // [R09]

	logic [15:0] rd_data;
	logic        rd_valid;
	logic [15:0] next_rd_data;

	// read port; unknown codes answer zero
	always_comb begin
		case (CMD_CODE_I)
			CMD_OV_FAULT_THR: next_rd_data = {4'h0, fault_thr}; // [R03]
			CMD_OV_FAULT_ACT: next_rd_data = {8'h00, fault_act};
			CMD_OV_WARN_THR:  next_rd_data = {4'h0, warn_thr}; // [R18]
			default:          next_rd_data = 16'h0000;
		endcase
		if (!CMD_RD_I)
			next_rd_data = rd_data;
	end

	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			rd_data  <= 16'h0000;
			rd_valid <= 1'b0;
		end else begin
			rd_data  <= next_rd_data;
			rd_valid <= CMD_RD_I;
		end
	end

	assign RD_DATA_O  = rd_data;
	assign RD_VALID_O = rd_valid;

	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (RST_I);

	// checks on configuration, flags and response
	fault_reject_a: assert property (wr_fault && !fault_ok && !RESTORE_I // [R01]
		|=> fault_thr == $past(fault_thr) && status_byte[SB_CML]
		&& status_cml[SC_INVALID_DATA])
		else $error("rejected fault threshold write changed state or flags missing");
	fault_order_a: assert property (wr_fault && fault_ok && !RESTORE_I // [R02]
		|=> fault_thr > warn_thr)
		else $error("accepted fault threshold not above warning");
	rd_upper_a: assert property (CMD_RD_I && CMD_CODE_I != CMD_OV_FAULT_ACT // [R03]
		|=> RD_VALID_O && RD_DATA_O[15:12] == 4'h0)
		else $error("threshold read shows nonzero upper bits");
	store_mask_a: assert property (STORE_I // [R05]
		|=> nv_fault == $past(fault_thr[MANT_W-1:NV_FAULT_LO]))
		else $error("stored fault image wrong");
	fault_flags_a: assert property (ov_fault_det // [R06]
		|=> status_byte[SB_OV_FAULT] && status_vsum && status_vout[SV_OV_FAULT]
		&& (ALERT_O || ALERT_MASK_I))
		else $error("overvoltage fault flags or alert missing");
	act_fixed_a: assert property (fault_act[2:0] == ACT_DELAY_CODE // [R07]
		&& !fault_act[ACT_ZERO_BIT])
		else $error("fixed action bits wrong");
	ignore_run_a: assert property (state == ST_RUN && ENABLE_I // [R09]
		&& !fault_act[ACT_SELECT_BIT] |=> OUTPUT_EN_O)
		else $error("ignore mode stopped the output");
	shutdown_a: assert property (state == ST_RUN && ov_fault_det // [R10]
		&& fault_act[ACT_SELECT_BIT] |=> !OUTPUT_EN_O)
		else $error("fault did not shut down");
	latch_hold_a: assert property (state == ST_LATCHED && !CLEAR_FAULTS_I // [R11]
		|=> !OUTPUT_EN_O)
		else $error("latched off output restarted");
	retry_legal_a: assert property (fault_act[ACT_RETRY_HI:ACT_RETRY_LO] == RETRY_NEVER // [R13]
		|| fault_act[ACT_RETRY_HI:ACT_RETRY_LO] == RETRY_ALWAYS)
		else $error("illegal retry policy held");
	retry_start_a: assert property (state == ST_RETRY_WAIT && $past(state) == ST_RUN // [R12]
		|-> wait_cnt == RETRY_CYCLES)
		else $error("retry delay not loaded");
	warn_reject_a: assert property (wr_warn && !warn_ok && !RESTORE_I // [R15]
		|=> warn_thr == $past(warn_thr) && status_cml[SC_INVALID_DATA])
		else $error("rejected warning write changed state");
	warn_flags_a: assert property (ov_warn_det // [R17]
		|=> status_byte[SB_OTHER] && status_vsum && status_vout[SV_OV_WARN])
		else $error("overvoltage warning flags missing");
	restore_warn_a: assert property (RESTORE_I |=> warn_thr < fault_thr) // [R19]
		else $error("restored warning not below fault");

	shutdown_c: cover property (state == ST_RUN ##1 state == ST_RETRY_WAIT);
	latch_c: cover property (state == ST_RUN ##1 state == ST_LATCHED);
	reject_c: cover property (reject ##1 ALERT_O);
	accept_c: cover property (wr_fault && fault_ok);

endmodule
`default_nettype wire

/* tb/ovcfg_host.sv */
// host-side command master for the overvoltage command set
// assumes the device takes strobes on the rising edge of clk_i
`timescale 1ns/100ps
`default_nettype none
module ovcfg_host (
	input  wire logic        clk_i,
	input  wire logic        rd_valid_i,
	input  wire logic [15:0] rd_data_i,
	output logic             wr_o,
	output logic             rd_o,
	output logic [7:0]       code_o,
	output logic [15:0]      data_o,
	output logic             store_o,
	output logic             restore_o,
	output logic             clear_o
);
	// idle bus at time zero
	initial begin
		{wr_o, rd_o, store_o, restore_o, clear_o} = 5'h00;
		code_o = 8'hFF;
		data_o = 16'hA5A5;
	end
	// write: code and data held with the strobe until the taking edge
	task automatic write_cmd(input logic [7:0] code, input logic [15:0] data);
		@(posedge clk_i);
		#1;
		wr_o = 1'b1;
		code_o = code;
		data_o = data;
		@(posedge clk_i);
		#1;
		wr_o = 1'b0;
		code_o = ~code; // released lines must not look valid
		data_o = ~data;
	endtask
	// read: answer is sampled just after the edge that took the strobe
	task automatic read_cmd(input logic [7:0] code, output logic [15:0] data,
		output logic valid);
		@(posedge clk_i);
		#1;
		rd_o = 1'b1;
		code_o = code;
		@(posedge clk_i);
		#1;
		rd_o = 1'b0;
		code_o = ~code;
		valid = rd_valid_i;
		data = rd_data_i;
	endtask
	// one-cycle control pulse: {store, restore, clear}
	task automatic pulse(input logic [2:0] sel);
		@(posedge clk_i);
		#1;
		{store_o, restore_o, clear_o} = sel;
		@(posedge clk_i);
		#1;
		{store_o, restore_o, clear_o} = 3'h0;
	endtask
endmodule
`default_nettype wire

/* tb/ovcfg_bench.sv */
// self-checking bench for the overvoltage limit and response logic
// assumes ovcfg_pkg and ovcfg_top compiled first; short ramp for speed
`timescale 1ns/100ps
`default_nettype none
module ovcfg_bench;
	import ovcfg_pkg::*;
	localparam int RAMPS = 4;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        wr, rd, store, restore, clr, rvalid, alert, out_en;
	logic        enable = 1'b0;
	logic        mask = 1'b0;
	logic [7:0]  code, sbyte, svout, scml;
	logic [15:0] wdata, rdata, sword;
	logic [11:0] meas = 12'h000;
	logic [11:0] setp = 12'h100;
	logic [15:0] scale = 16'h1000;
	logic [15:0] act;
	logic [15:0] warn_try [4] = '{16'h0080, 16'h0086, 16'h0399, 16'h0087};
	logic [15:0] fault_bad [2] = '{16'h039A, 16'h0267};
	int          miscompares = 0;
	int          n_tests = 0;
	int          n;
	// 250 MHz core clock
	always #2 clk = ~clk;
	ovcfg_host host (.clk_i(clk), .rd_valid_i(rvalid), .rd_data_i(rdata), .wr_o(wr),
		.rd_o(rd), .code_o(code), .data_o(wdata), .store_o(store), .restore_o(restore),
		.clear_o(clr));
	ovcfg_top #(.RAMP_CYCLES(RAMPS)) uut (.CLOCK_I(clk), .RST_I(rst), .CMD_WR_I(wr),
		.CMD_RD_I(rd), .CMD_CODE_I(code), .CMD_DATA_I(wdata), .STORE_I(store),
		.RESTORE_I(restore), .CLEAR_FAULTS_I(clr), .ENABLE_I(enable), .ALERT_MASK_I(mask),
		.VOUT_MEAS_I(meas), .VOUT_SETPOINT_I(setp), .VOUT_SCALE_LOOP_I(scale),
		.RD_DATA_O(rdata), .RD_VALID_O(rvalid), .STATUS_BYTE_O(sbyte),
		.STATUS_WORD_O(sword), .STATUS_VOUT_O(svout), .STATUS_CML_O(scml),
		.ALERT_O(alert), .OUTPUT_EN_O(out_en));
	// single comparison point, four-state exact
	task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// register read through the host, answer must come with the valid pulse
	task automatic check_reg(input logic [7:0] c, input logic [15:0] exp);
		logic [15:0] d;
		logic        v;
		host.read_cmd(c, d, v);
		check_word("read valid", 16'h0001, {15'h0000, v});
		check_word("register read", exp, d);
	endtask
	// all status views at once; alert follows any flag unless masked
	task automatic check_status(input logic [7:0] sb, input logic [7:0] sv, input logic [7:0] sc);
		check_word("status byte", {8'h00, sb}, {8'h00, sbyte});
		check_word("status word", {|sv, 7'h00, sb}, sword);
		check_word("status vout", {8'h00, sv}, {8'h00, svout});
		check_word("status cml", {8'h00, sc}, {8'h00, scml});
		check_word("alert", {15'h0000, (|{sb, sv, sc}) & ~mask}, {15'h0000, alert});
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic clear_flags();
		host.pulse(3'h1);
		step(1);
	endtask
	task automatic close_out();
		$display("mismatches %0d comparisons %0d", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// a hang costs far more than the few hundred cycles the tests need
	initial begin
		#100000;
		miscompares++;
		close_out();
	end
	initial begin
		step(2);
		rst = 1'b0;
		// reset values and read-only fields
		check_status(8'h00, 8'h00, 8'h00);
		check_reg(CMD_OV_FAULT_THR, 16'h0290);
		check_reg(8'h7E, 16'h0000);
		check_reg(CMD_OV_FAULT_ACT, 16'h00BF);
		check_reg(CMD_OV_WARN_THR, 16'h0267);
		host.write_cmd(CMD_OV_FAULT_THR, 16'hF2A0);
		check_reg(CMD_OV_FAULT_THR, 16'h02A0);
		host.write_cmd(CMD_OV_FAULT_THR, 16'h0399);
		check_reg(CMD_OV_FAULT_THR, 16'h0399);
		check_status(8'h00, 8'h00, 8'h00);
		// 922 itself and a value equal to the warning are both refused
		for (int i = 0; i < 2; i++) begin
			mask = (i == 1);
			host.write_cmd(CMD_OV_FAULT_THR, fault_bad[i]);
			step(1);
			check_reg(CMD_OV_FAULT_THR, 16'h0399);
			check_status(8'h02, 8'h00, 8'h40);
			clear_flags();
		end
		mask = 1'b0;
		// every retry code: only all-zero and all-one are kept
		act = 16'h00BF;
		for (logic [3:0] r = 4'h0; r < 4'h8; r++) begin
			host.write_cmd(CMD_OV_FAULT_ACT, {10'h000, r[2:0], 3'h0} | 16'h0040);
			step(1);
			if (r == 4'h0 || r == 4'h7)
				act = {10'h000, r[2:0], 3'h7};
			check_reg(CMD_OV_FAULT_ACT, act);
			check_status((r == 4'h0 || r == 4'h7) ? 8'h00 : 8'h02, 8'h00,
				(r == 4'h0 || r == 4'h7) ? 8'h00 : 8'h40);
			clear_flags();
		end
		// warning limits: setpoint, scale product, fault, then a legal one
		setp = 12'h080;
		scale = 16'h2000;
		for (int i = 0; i < 4; i++) begin
			host.write_cmd(CMD_OV_WARN_THR, warn_try[i]);
			step(1);
			check_reg(CMD_OV_WARN_THR, (i < 3) ? 16'h0267 : 16'h0087);
			check_status((i < 3) ? 8'h02 : 8'h00, 8'h00, (i < 3) ? 8'h40 : 8'h00);
			clear_flags();
		end
		setp = 12'h100;
		scale = 16'h1000;
		host.write_cmd(CMD_OV_WARN_THR, 16'h0300);
		check_reg(CMD_OV_WARN_THR, 16'h0300);
		// ignore mode: warning then fault, output keeps running
		enable = 1'b1;
		meas = 12'h300;
		step(3);
		check_word("output enable", 16'h0001, {15'h0000, out_en});
		check_status(8'h00, 8'h00, 8'h00);
		meas = 12'h301;
		step(2);
		check_status(8'h01, 8'h40, 8'h00);
		meas = 12'h39A;
		step(2);
		check_status(8'h21, 8'hC0, 8'h00);
		check_word("output enable", 16'h0001, {15'h0000, out_en});
		// clear while both conditions persist: the set must win that edge
		host.pulse(3'h1);
		check_status(8'h21, 8'hC0, 8'h00);
		meas = 12'h000;
		clear_flags();
		// shutdown with endless retry: restart after seven ramp times
		host.write_cmd(CMD_OV_FAULT_ACT, 16'h00B8);
		check_reg(CMD_OV_FAULT_ACT, 16'h00BF);
		meas = 12'h39A;
		step(2);
		meas = 12'h000;
		check_word("output enable", 16'h0000, {15'h0000, out_en});
		check_status(8'h21, 8'hC0, 8'h00);
		n = 0;
		while (out_en !== 1'b1 && n < 100) begin
			step(1);
			n++;
		end
		check_word("restart window", 16'h0001,
			{15'h0000, n >= 7 * RAMPS - 3 && n <= 7 * RAMPS});
		// commanded off during the retry wait: restart must not wait the delay out
		meas = 12'h39A;
		step(2);
		meas = 12'h000;
		enable = 1'b0;
		step(1);
		check_word("output enable", 16'h0000, {15'h0000, out_en});
		enable = 1'b1;
		step(3);
		check_word("output enable", 16'h0001, {15'h0000, out_en});
		clear_flags();
		// no retry: stays off until faults are cleared
		host.write_cmd(CMD_OV_FAULT_ACT, 16'h0080);
		check_reg(CMD_OV_FAULT_ACT, 16'h0087);
		meas = 12'h39A;
		step(2);
		meas = 12'h000;
		step(7 * RAMPS + 4);
		check_word("output enable", 16'h0000, {15'h0000, out_en});
		clear_flags();
		step(3);
		check_word("output enable", 16'h0001, {15'h0000, out_en});
		// store, overwrite, restore: low nibble lost, warning derived
		host.write_cmd(CMD_OV_FAULT_THR, 16'h038F);
		host.pulse(3'h4);
		host.write_cmd(CMD_OV_FAULT_THR, 16'h0350);
		host.write_cmd(CMD_OV_FAULT_ACT, 16'h0038);
		host.pulse(3'h2);
		step(1);
		check_reg(CMD_OV_FAULT_THR, 16'h0380);
		check_reg(CMD_OV_FAULT_ACT, 16'h0087);
		check_reg(CMD_OV_WARN_THR, 16'h0348);
		setp = 12'h350;
		host.pulse(3'h2);
		step(1);
		check_reg(CMD_OV_WARN_THR, 16'h037F);
		close_out();
	end
endmodule
`default_nettype wire
